//--- sfr_pkg.sv
package sfr_pkg;
  // Register address and field layout.
  localparam logic [7:0] SFR_ADDR_FADE = 8'h13;
  localparam logic [7:0] SFR_FADE_RESET = 8'h00;
  localparam int SFR_OUT_MSB = 7;
  localparam int SFR_OUT_LSB = 4;
  localparam int SFR_IN_MSB = 3;
  localparam int SFR_IN_LSB = 0;
  localparam logic [3:0] SFR_CODE_OFF = 4'h0;
  localparam logic [3:0] SFR_CODE_KNEE = 4'ha;
  // Ramp times in milliseconds.
  localparam int SFR_STEP_LO_MS = 300;
  localparam int SFR_STEP_HI_MS = 500;
  localparam int SFR_KNEE_MS = 3000;
  // Clock rate and one-millisecond tick.
  localparam int SFR_CLK_HZ = 20000000;
  localparam int SFR_MS_CYCLES = SFR_CLK_HZ / 1000;
  // Microsecond ticks in one millisecond, the unit of the ramp prescaler.
  localparam int SFR_US_PER_MS = 1000;
  // Full-scale current code width.
  localparam int SFR_LVL_W = 7;
  localparam logic [6:0] SFR_LVL_FULL = 7'h7f;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_wr_t;

  typedef struct packed {
    logic [12:0] out_ms;
    logic [12:0] in_ms;
    logic out_en;
    logic in_en;
  } sfr_dur_t;

  typedef enum logic [1:0] {
    SFR_IDLE = 2'b00,
    SFR_RISE = 2'b01,
    SFR_FALL = 2'b10
  } sfr_dir_t;

  // Full-scale ramp time in ms for a four-bit code.
  function automatic logic [12:0] sfr_code_ms(input logic [3:0] code);
    int ms;
    if (code <= SFR_CODE_KNEE) begin
      ms = int'(code) * SFR_STEP_LO_MS;
    end else begin
      ms = SFR_KNEE_MS + (int'(code) - int'(SFR_CODE_KNEE)) * SFR_STEP_HI_MS;
    end
    return ms[12:0];
  endfunction
endpackage

//--- sfr_decode.sv
`timescale 1ns/10ps
module sfr_decode (
  // Register value.
  input wire logic [7:0] fade_rates,
  // Decoded durations.
  output sfr_pkg::sfr_dur_t dur
);
  import sfr_pkg::*;
  logic [3:0] out_code;
  logic [3:0] in_code;
  assign out_code = fade_rates[SFR_OUT_MSB:SFR_OUT_LSB]; // R1
  assign in_code = fade_rates[SFR_IN_MSB:SFR_IN_LSB]; // R2
  assign dur.out_ms = sfr_code_ms(out_code); // R3
  assign dur.in_ms = sfr_code_ms(in_code); // R4
  assign dur.out_en = (out_code != SFR_CODE_OFF); // R1
  assign dur.in_en = (in_code != SFR_CODE_OFF); // R2
endmodule

//--- sfr_fade_cfg.sv
`timescale 1ns/10ps
// How it works
// R1 - The fade-out code is bits 7:4 of the fade register, and code zero makes the current drop at once.
// R2 - The fade-in code is bits 3:0 of the fade register, and code zero makes the current rise at once.
// R3 - Fade-out full-scale time is code times 0.30 s up to code ten, then 0.5 s more per code up to 5.5 s.
// R4 - Fade-in full-scale time follows the same sixteen-code schedule as fade-out.
// R5 - The time per current step is the full-scale time over the full-scale range, so short swings end sooner.
// R6 - Rising current uses the fade-in time and falling current uses the fade-out time.
module sfr_fade_cfg #(
  parameter int MS_CYCLES = sfr_pkg::SFR_MS_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register write and read port.
  input sfr_pkg::sfr_wr_t reg_wr,
  output logic [7:0] sink_fade_rates,
  // Ramp request and level.
  input wire logic [6:0] target_level,
  output logic [6:0] sink_level,
  output logic fading,
  output sfr_pkg::sfr_dur_t dur
);
  import sfr_pkg::*;

  // Clock cycles in one microsecond tick of the ramp prescaler.
  localparam int TICK_CYCLES = MS_CYCLES / SFR_US_PER_MS;
  // Longest stretch without a level step: one step of the slowest code.
  localparam int GAP_MAX = ((SFR_KNEE_MS + (15 - int'(SFR_CODE_KNEE)) * SFR_STEP_HI_MS) * SFR_US_PER_MS
    / int'(SFR_LVL_FULL) + 1) * TICK_CYCLES;

  logic [7:0] rates_q, rates_d;
  logic [6:0] lvl_q, lvl_d;
  logic [31:0] pre_q, pre_d;
  logic [19:0] acc_q, acc_d;
  sfr_dir_t dir;
  logic [12:0] span_ms;
  logic [19:0] step_cycles;
  logic [31:0] gap_q, gap_d;

  sfr_decode u_dec (
    .fade_rates(rates_q),
    .dur(dur)
  );

  always_comb begin
    rates_d = rates_q;
    if (reg_wr.wr && reg_wr.addr == SFR_ADDR_FADE) begin
      rates_d = reg_wr.wdata;
    end
  end

  // Direction picks which duration drives the ramp.
  always_comb begin
    if (target_level > lvl_q) begin
      dir = SFR_RISE;
    end else if (target_level < lvl_q) begin
      dir = SFR_FALL;
    end else begin
      dir = SFR_IDLE;
    end
  end

  always_comb begin
    case (dir)
      SFR_RISE: span_ms = dur.in_ms; // R6
      SFR_FALL: span_ms = dur.out_ms; // R6
      default: span_ms = '0;
    endcase
  end

  // Microsecond ticks per one code step: full-scale time spread over 127 steps.
  // A swing of fewer codes therefore ends in proportionally less time.
  assign step_cycles = 20'((32'(span_ms) * 32'(SFR_US_PER_MS)) / 32'(SFR_LVL_FULL)); // R5

  always_comb begin
    lvl_d = lvl_q;
    pre_d = pre_q;
    acc_d = acc_q;
    case (dir)
      SFR_IDLE: begin
        pre_d = '0;
        acc_d = '0;
      end
      SFR_RISE, SFR_FALL: begin
        if ((dir == SFR_RISE && !dur.in_en) || (dir == SFR_FALL && !dur.out_en)) begin
          lvl_d = target_level; // R1 R2
          acc_d = '0;
        end else if (pre_q + 32'd1 >= 32'(TICK_CYCLES)) begin
          pre_d = '0;
          if (acc_q + 20'd1 >= step_cycles) begin
            acc_d = '0;
            lvl_d = (dir == SFR_RISE) ? lvl_q + 7'h01 : lvl_q - 7'h01; // R5
          end else begin
            acc_d = acc_q + 20'd1;
          end
        end else begin
          pre_d = pre_q + 32'd1;
        end
      end
      default: begin
        lvl_d = lvl_q;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rates_q <= SFR_FADE_RESET;
      lvl_q <= '0;
      pre_q <= '0;
      acc_q <= '0;
    end else begin
      rates_q <= rates_d;
      lvl_q <= lvl_d;
      pre_q <= pre_d;
      acc_q <= acc_d;
    end
  end

  // Counts cycles of an active fade since the level last moved; only the checks read it.
  always_comb begin
    gap_d = '0;
    if (dir != SFR_IDLE && lvl_d == lvl_q) begin
      gap_d = gap_q + 32'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_d;
    end
  end

  assign sink_fade_rates = rates_q;
  assign sink_level = lvl_q;
  assign fading = (dir != SFR_IDLE);

  AST_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr.wr && reg_wr.addr == SFR_ADDR_FADE |=> sink_fade_rates == $past(reg_wr.wdata))
    else $error("fade register write lost");
  AST_OUT_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
    dir == SFR_FALL && !dur.out_en |=> sink_level == $past(target_level))
    else $error("fade-out disabled but level ramped");
  AST_IN_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
    dir == SFR_RISE && !dur.in_en |=> sink_level == $past(target_level))
    else $error("fade-in disabled but level ramped");
  AST_OUT_MS: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    rates_q[7:4] == 4'hf |-> dur.out_ms == 13'd5500)
    else $error("fade-out code fifteen not 5.5 s");
  AST_IN_MS: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
    rates_q[3:0] == 4'h1 |-> dur.in_ms == 13'd300)
    else $error("fade-in code one not 0.30 s");
  AST_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    $changed(sink_level) && $past(dir) == SFR_RISE && $past(dur.in_en) |-> sink_level == $past(sink_level) + 7'h01)
    else $error("rising ramp moved more than one step");
  AST_DIR: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
    target_level > sink_level |=> sink_level >= $past(sink_level))
    else $error("level fell while rising");
  AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dir == SFR_IDLE && $stable(target_level) |=> $stable(sink_level))
    else $error("level moved with no fade");
  CV_RISE: cover property (@(posedge ref_clk) disable iff (!rst_n) dir == SFR_RISE && dur.in_en ##1 $changed(sink_level));
  CV_FALL: cover property (@(posedge ref_clk) disable iff (!rst_n) dir == SFR_FALL && dur.out_en ##1 $changed(sink_level));
  CV_SNAP: cover property (@(posedge ref_clk) disable iff (!rst_n) dir == SFR_RISE && !dur.in_en);
  CV_DROP: cover property (@(posedge ref_clk) disable iff (!rst_n) dir == SFR_FALL && !dur.out_en);
  CV_DONE: cover property (@(posedge ref_clk) disable iff (!rst_n) dir == SFR_RISE ##1 dir == SFR_IDLE);

  // A falling ramp moves down by exactly one code per step.
  AST_FALL_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    $changed(sink_level) && $past(dir) == SFR_FALL && $past(dur.out_en) |-> sink_level == $past(sink_level) - 7'h01)
    else $error("falling ramp moved more than one step");

  // While the target lies below, the level never climbs.
  AST_FALL_DIR: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
    target_level < sink_level |=> sink_level <= $past(sink_level))
    else $error("level rose while falling");

  // A rising fade never passes its target.
  AST_RISE_CAP: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    dir == SFR_RISE |=> sink_level <= $past(target_level))
    else $error("rising fade overshot target");

  // A falling fade never passes its target.
  AST_FALL_CAP: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    dir == SFR_FALL |=> sink_level >= $past(target_level))
    else $error("falling fade undershot target");

  // First code above the knee adds half a second to the three-second point.
  AST_OUT_KNEE: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    rates_q[SFR_OUT_MSB:SFR_OUT_LSB] == 4'hb |-> dur.out_ms == 13'd3500)
    else $error("fade-out code eleven not 3.5 s");

  // The knee code itself ends the 0.30 s schedule at three seconds.
  AST_IN_KNEE: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
    rates_q[SFR_IN_MSB:SFR_IN_LSB] == SFR_CODE_KNEE |-> dur.in_ms == 13'd3000)
    else $error("fade-in code ten not 3.0 s");

  // A zero upper code turns the fade-out off.
  AST_OUT_EN: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
    rates_q[SFR_OUT_MSB:SFR_OUT_LSB] == SFR_CODE_OFF |-> !dur.out_en)
    else $error("fade-out enabled with code zero");

  // A zero lower code turns the fade-in off.
  AST_IN_EN: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
    rates_q[SFR_IN_MSB:SFR_IN_LSB] == SFR_CODE_OFF |-> !dur.in_en)
    else $error("fade-in enabled with code zero");

  // Writes to any other address leave the fade register alone.
  AST_REFUSED: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr.wr && reg_wr.addr != SFR_ADDR_FADE |=> $stable(sink_fade_rates))
    else $error("fade register changed by foreign write");

  // Reset clears the register and the level.
  AST_RESET: assert property (@(posedge ref_clk)
    !rst_n |=> sink_level == 7'h00 && sink_fade_rates == SFR_FADE_RESET)
    else $error("reset did not clear state");

  // An active fade never stalls longer than one step of the slowest code.
  AST_GAP: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    gap_q <= 32'(GAP_MAX))
    else $error("fade stalled between steps");
endmodule

//--- tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
  import sfr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  sfr_wr_t reg_wr = '0;
  logic [6:0] target_level = 7'h00;
  logic [7:0] sink_fade_rates;
  logic [6:0] sink_level;
  logic fading;
  sfr_dur_t dur;
  int n_errors = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h5233;
  always #25 ref_clk = ~ref_clk;
  sfr_fade_cfg #(.MS_CYCLES(1000)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .sink_fade_rates(sink_fade_rates), .target_level(target_level), .sink_level(sink_level),
    .fading(fading), .dur(dur));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int ms_of(input int c);
    return (c <= 10) ? c * 300 : 3000 + (c - 10) * 500;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_wr.wr <= 1'b0;
    #1;
  endtask
  task automatic chk_reg(input logic [7:0] v);
    `CHK(sink_fade_rates, v)
    `CHK({dur.out_ms, dur.out_en}, {13'(ms_of(v[7:4])), v[7:4] != 4'h0})
    `CHK({dur.in_ms, dur.in_en}, {13'(ms_of(v[3:0])), v[3:0] != 4'h0})
  endtask
  // The span is bounded by the step count of the swing, not by full scale.
  task automatic ramp(input logic [6:0] tgt, input int ms);
    int s;
    int n;
    int cnt;
    s = ms * 1000 / 127;
    n = (tgt > sink_level) ? tgt - sink_level : sink_level - tgt;
    @(posedge ref_clk);
    target_level <= tgt;
    #1;
    `CHK(fading, 1'b1)
    cnt = 0;
    while (sink_level !== tgt && cnt < 30000) begin
      @(posedge ref_clk);
      cnt++;
      #1;
    end
    `CHK(sink_level, tgt)
    `CHK(fading, 1'b0)
    `CHK(cnt > (n - 1) * s && cnt <= n * s + 4, 1'b1)
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #5000000;
    n_errors++;
    test_done();
  end
  initial begin
    logic [7:0] v;
    logic [7:0] a;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk_reg(8'h00);
    `CHK(sink_level, 7'h00)
    for (int c = 0; c < 16; c++) begin
      v = {c[3:0], 4'(xs())};
      wr(SFR_ADDR_FADE, v);
      chk_reg(v);
      v = {4'(xs()), c[3:0]};
      wr(SFR_ADDR_FADE, v);
      chk_reg(v);
    end
    a = 8'(xs());
    if (a == SFR_ADDR_FADE) begin
      a ^= 8'h01;
    end
    wr(a, ~v);
    chk_reg(v);
    $display("test codes done");
    wr(SFR_ADDR_FADE, 8'h00);
    ramp(7'd40, 0);
    ramp(7'd20, 0);
    $display("test no fade done");
    wr(SFR_ADDR_FADE, 8'hf1);
    ramp(7'd22, ms_of(1));
    wr(SFR_ADDR_FADE, 8'h1f);
    ramp(7'd20, ms_of(1));
    $display("test ramps done");
    test_done();
  end
endmodule
